// *** src/tpw_chan.sv ***
// one pwm channel: explicit high/low run or smooth density accumulator
`timescale 1ns/100ps
`default_nettype none
module tpw_chan (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_tick,
   input wire logic i_load,
   input wire logic i_stop,
   input wire tpw_pkg::tpw_cfg_s i_cfg,
   output logic o_level
);
   import tpw_pkg::*;

   tpw_cfg_s cfg, next_cfg;
   logic [12:0] cnt, next_cnt;
   logic [10:0] acc, next_acc;
   logic level, next_level;
   logic [12:0] period;
   logic [10:0] sum;

   // ======================================================================
   // next state; the 13-bit count covers two full 12-bit phases
   always_comb begin
      next_cfg = cfg;
      next_cnt = cnt;
      next_acc = acc;
      next_level = level;
      period = {1'b0, cfg.hi} + {1'b0, cfg.lo}; // [R8]
      sum = acc + {1'b0, cfg.hi[9:0]};
      if (i_stop) begin
         next_cnt = 13'h0000;
         next_acc = 11'h000;
         next_level = 1'b0;
      end else if (i_load) begin
         // restart so the first tick lands on the high phase
         next_cfg = i_cfg; // [R19]
         next_cnt = 13'h0000; // [R19]
         next_acc = 11'h000;
      end else if (i_tick) begin
         if (cfg.kind == TPW_KIND_EXPL) begin
            next_level = (cnt < {1'b0, cfg.hi}); // [R6]
            if (cnt + 13'h0001 >= period) begin
               next_cnt = 13'h0000; // [R6]
            end else begin
               next_cnt = cnt + 13'h0001;
            end
         end else if (sum >= {1'b0, cfg.win}) begin
            // spreading highs evenly; half scale alternates every tick
            next_level = 1'b1; // [R18] [R16]
            next_acc = sum - {1'b0, cfg.win};
         end else begin
            next_level = 1'b0; // [R18]
            next_acc = sum;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg <= '0;
         cnt <= 13'h0000;
         acc <= 11'h000;
         level <= 1'b0;
      end else begin
         cfg <= next_cfg;
         cnt <= next_cnt;
         acc <= next_acc;
         level <= next_level;
      end
   end

   assign o_level = level;

   // ======================================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   expl_high_run_a: assert property ( // [R6]
      (i_tick && !i_load && !i_stop && cfg.kind == TPW_KIND_EXPL && cnt < {1'b0, cfg.hi})
      |=> level && $stable(cfg))
      else $error("explicit channel not high during high phase");
   expl_low_run_a: assert property ( // [R6]
      (i_tick && !i_load && !i_stop && cfg.kind == TPW_KIND_EXPL && cnt >= {1'b0, cfg.hi})
      |=> !level)
      else $error("explicit channel not low during low phase");
   smooth_acc_bound_a: assert property ( // [R18]
      (cfg.kind == TPW_KIND_SMOOTH && !i_load) |-> acc < {1'b0, cfg.win})
      else $error("smooth accumulator beyond window");
   load_restart_a: assert property ( // [R19]
      (i_load && !i_stop) |=> cnt == 13'h0000 && acc == 11'h000)
      else $error("reload did not restart counters");
   smooth_toggle_c: cover property (
      (cfg.kind == TPW_KIND_SMOOTH && i_tick && level) ##1 !level);
endmodule
`default_nettype wire

// *** src/tpw_pkg.sv ***
// constants, field layouts and carrier types of the tick based pwm block
package tpw_pkg;
   // ======================================================================
   // sizes
   localparam int NUM_SLOTS = 8;
   localparam int NUM_PINS = 20;
   // ======================================================================
   // timing: one system tick per millisecond at a 50 ns clock
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // ======================================================================
   // argument codes and full scales
   localparam logic [16:0] LOW_ARG_PCT = 17'h00000;
   localparam logic [16:0] LOW_SMOOTH_PCT = 17'h02710;
   localparam logic [16:0] LOW_SMOOTH_PM = 17'h186A0;
   localparam logic [11:0] PCT_FULL = 12'h064;
   localparam logic [11:0] PM_FULL = 12'h3E8;
   localparam logic [11:0] CNT_MAX = 12'hFFF;
   localparam logic [9:0] WIN_PCT = 10'h064;
   localparam logic [9:0] WIN_PM = 10'h3E8;
   // ======================================================================
   // pin mode codes
   localparam logic [4:0] MODE_OUT_PP = 5'h08;
   localparam logic [4:0] MODE_OUT_OD = 5'h09;
   localparam logic [4:0] MODE_PCT_PP = 5'h12;
   localparam logic [4:0] MODE_PCT_OD = 5'h13;
   localparam logic [4:0] MODE_PM_PP = 5'h1C;
   localparam logic [4:0] MODE_PM_OD = 5'h1D;
   localparam logic [4:0] RST_MODE = 5'h00;
   // ======================================================================
   // register byte offsets
   localparam logic [7:0] ADDR_CMD_PIN = 8'h00;
   localparam logic [7:0] ADDR_CMD_HIGH = 8'h04;
   localparam logic [7:0] ADDR_CMD_LOW = 8'h08;
   localparam logic [7:0] ADDR_CMD_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_PIN_WRITE = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_LEVELS = 8'h18;
   localparam logic [7:0] ADDR_MODE_BASE = 8'h40;
   localparam logic [7:0] ADDR_MODE_LAST = 8'h8C;
   // ======================================================================
   // field positions
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int CTRL_ABORT_BIT = 2;
   localparam int PW_VAL_LSB = 16;
   localparam int ST_REFUSED_BIT = 8;
   // ======================================================================
   // types
   typedef enum logic [0:0] {
      TPW_KIND_EXPL = 1'b0,
      TPW_KIND_SMOOTH = 1'b1
   } tpw_kind_e;
   typedef struct packed {
      tpw_kind_e kind;
      logic [11:0] hi;
      logic [11:0] lo;
      logic [9:0] win;
   } tpw_cfg_s;
   typedef struct packed {
      logic [4:0] pin;
      logic [11:0] high;
      logic [16:0] low;
   } tpw_cmd_s;
endpackage

// *** src/tpw_top.sv ***
// tick based pwm outputs: apb registers, slot pool, pin drivers
//
// Functional notes
// R1: at most eight channels active; a request beyond that gets no slot.
// R2: all channel timing advances on one 1 ms tick.
// R3: software must set the pin as digital output before applying pwm.
// R4: command with pin zero, or clear, deactivates every channel at once.
// R5: high and low both zero frees only that pin's slot.
// R6: explicit mode: high for high ticks, low for low ticks, repeating.
// R7: pin selector accepts 1 to 20; pin 20 is the indicator led.
// R8: explicit high and low counts are 12 bits, 0 to 4095 ticks.
// R9: low zero means high is a percentage of a 100 tick cycle.
// R10: percentage above 100 saturates to 100, constant high.
// R11: low code 10000 spreads percentage evenly over 100 ms.
// R12: low code 100000 spreads per-mille evenly over one second.
// R13: pin modes 18 and 19 turn pin writes into smooth percent requests.
// R14: pin modes 28 and 29 turn pin writes into smooth per-mille requests.
// R15: user abort stops all channels and drives their pins low.
// R16: smooth half scale toggles the output every tick.
// R17: mode 8 drives push-pull, mode 9 open-drain, high for one.
// R18: smooth modes use a per-channel accumulator crossing the window.
// R19: new or reprogrammed channel restarts at its high phase next tick.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module tpw_top #(
   parameter int P_TICK_CYCLES = tpw_pkg::TICK_CYCLES
) (
   input wire logic I_CLK_SYS,
   input wire logic I_SYS_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic O_PREADY,
   output logic [31:0] O_PRDATA,
   output logic O_PSLVERR,
   input wire logic I_USER_ABORT,
   output logic [19:0] O_PIN_LEVEL,
   output logic [19:0] O_PIN_OE_N
);
   import tpw_pkg::*;

   // ======================================================================
   // helpers
   function automatic logic [5:0] mode_decode(input logic [7:0] a);
      logic [7:0] off;
      off = a - ADDR_MODE_BASE;
      mode_decode = 6'h00;
      if (a >= ADDR_MODE_BASE && a <= ADDR_MODE_LAST && a[1:0] == 2'b00) begin
         mode_decode = {1'b1, off[6:2]};
      end
   endfunction

   function automatic logic pin_ok(input logic [4:0] p);
      pin_ok = (p != 5'h00) && (p <= 5'(NUM_PINS)); // [R7]
   endfunction

   function automatic tpw_cfg_s cmd_to_cfg(input tpw_cmd_s c);
      tpw_cfg_s f;
      f.kind = TPW_KIND_EXPL;
      f.hi = c.high; // [R8]
      f.lo = (c.low > {5'h00, CNT_MAX}) ? CNT_MAX : c.low[11:0];
      f.win = WIN_PCT;
      if (c.low == LOW_ARG_PCT) begin
         f.hi = (c.high > PCT_FULL) ? PCT_FULL : c.high; // [R9] [R10]
         f.lo = PCT_FULL - f.hi; // [R9]
      end else if (c.low == LOW_SMOOTH_PCT) begin
         f.kind = TPW_KIND_SMOOTH; // [R11]
         f.hi = (c.high > PCT_FULL) ? PCT_FULL : c.high;
         f.lo = 12'h000;
      end else if (c.low == LOW_SMOOTH_PM) begin
         f.kind = TPW_KIND_SMOOTH; // [R12]
         f.hi = (c.high > PM_FULL) ? PM_FULL : c.high;
         f.lo = 12'h000;
         f.win = WIN_PM;
      end
      return f;
   endfunction

   // ======================================================================
   // tick divider: one-cycle enable every millisecond
   logic [15:0] div_cnt, next_div_cnt;
   logic tick, next_tick;

   always_comb begin
      next_div_cnt = div_cnt + 16'h0001;
      next_tick = 1'b0;
      if (div_cnt == 16'(P_TICK_CYCLES - 1)) begin
         next_div_cnt = 16'h0000;
         next_tick = 1'b1; // [R2]
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         tick <= next_tick;
      end
   end

   // ======================================================================
   // abort pin synchroniser; only the second stage is used
   logic ab_s1, ab_s2;

   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ab_s1 <= 1'b0;
         ab_s2 <= 1'b0;
      end else begin
         ab_s1 <= I_USER_ABORT;
         ab_s2 <= ab_s1;
      end
   end

   // ======================================================================
   // register state
   logic [4:0] cmd_pin, next_cmd_pin;
   logic [11:0] cmd_high, next_cmd_high;
   logic [16:0] cmd_low, next_cmd_low;
   logic [4:0] mode [NUM_PINS];
   logic [4:0] next_mode [NUM_PINS];
   logic [19:0] static_lvl, next_static_lvl;
   logic [NUM_SLOTS-1:0] slot_act, next_slot_act, slot_load, slot_stop, chan_lvl;
   logic [4:0] slot_pin [NUM_SLOTS];
   logic [4:0] next_slot_pin [NUM_SLOTS];
   logic refused, next_refused;
   logic pready, next_pready, pslverr, next_pslverr;
   logic [31:0] prdata, next_prdata;
   logic [19:0] pin_out, next_pin_out, pin_oe_n, next_pin_oe_n;

   // bus decode shared by every group
   logic wr_en, ctrl_wr, pw_wr, go_cmd, clear_all, abort_now, smooth_pin;
   logic [4:0] pw_pin, pw_mode;
   logic [5:0] msel;
   tpw_cmd_s cmd_cur;
   tpw_cfg_s load_cfg;

   // zero wait states: ready raised for the cycle after setup
   always_comb begin
      wr_en = I_PSEL & I_PENABLE & I_PWRITE & pready;
      msel = mode_decode(I_PADDR);
      ctrl_wr = wr_en && (I_PADDR == ADDR_CMD_CTRL);
      pw_wr = wr_en && (I_PADDR == ADDR_PIN_WRITE);
      pw_pin = I_PWDATA[4:0];
      pw_mode = pin_ok(pw_pin) ? mode[5'(pw_pin - 5'h01)] : RST_MODE;
      smooth_pin = (pw_mode == MODE_PCT_PP) || (pw_mode == MODE_PCT_OD) ||
                   (pw_mode == MODE_PM_PP) || (pw_mode == MODE_PM_OD);
      cmd_cur = '{pin: cmd_pin, high: cmd_high, low: cmd_low};
      if (pw_wr) begin
         // pin write in a smooth mode becomes a pwm request [R13] [R14]
         cmd_cur.pin = pw_pin;
         cmd_cur.high = I_PWDATA[PW_VAL_LSB +: 12];
         cmd_cur.low = ((pw_mode == MODE_PM_PP) || (pw_mode == MODE_PM_OD)) ?
                       LOW_SMOOTH_PM : LOW_SMOOTH_PCT;
      end
      go_cmd = (ctrl_wr && I_PWDATA[CTRL_GO_BIT]) || (pw_wr && smooth_pin);
      clear_all = (ctrl_wr && I_PWDATA[CTRL_CLEAR_BIT]) ||
                  (go_cmd && cmd_cur.pin == 5'h00); // [R4]
      abort_now = ab_s2 || (ctrl_wr && I_PWDATA[CTRL_ABORT_BIT]); // [R15]
      load_cfg = cmd_to_cfg(cmd_cur);
   end

   // ======================================================================
   // apb read side and answer
   always_comb begin
      next_pready = I_PSEL & ~I_PENABLE;
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (I_PSEL & ~I_PENABLE) begin
         next_prdata = 32'h00000000;
         next_pslverr = 1'b0;
         if (I_PADDR == ADDR_CMD_PIN) begin
            next_prdata = {27'h0000000, cmd_pin};
         end else if (I_PADDR == ADDR_CMD_HIGH) begin
            next_prdata = {20'h00000, cmd_high};
         end else if (I_PADDR == ADDR_CMD_LOW) begin
            next_prdata = {15'h0000, cmd_low};
         end else if (I_PADDR == ADDR_CMD_CTRL || I_PADDR == ADDR_PIN_WRITE) begin
            next_prdata = 32'h00000000;
         end else if (I_PADDR == ADDR_STATUS) begin
            next_prdata = {23'h000000, refused, slot_act};
         end else if (I_PADDR == ADDR_LEVELS) begin
            next_prdata = {12'h000, pin_out};
         end else if (msel[5]) begin
            next_prdata = {27'h0000000, mode[msel[4:0]]};
         end else begin
            next_pslverr = 1'b1; // unmapped: error, no effect
         end
      end
   end

   // ======================================================================
   // writable registers; abort also forces pwm pins low afterwards
   always_comb begin
      next_cmd_pin = cmd_pin;
      next_cmd_high = cmd_high;
      next_cmd_low = cmd_low;
      next_mode = mode;
      next_static_lvl = static_lvl;
      if (wr_en && !pslverr) begin
         if (I_PADDR == ADDR_CMD_PIN) begin
            next_cmd_pin = I_PWDATA[4:0];
         end else if (I_PADDR == ADDR_CMD_HIGH) begin
            next_cmd_high = I_PWDATA[11:0];
         end else if (I_PADDR == ADDR_CMD_LOW) begin
            next_cmd_low = I_PWDATA[16:0];
         end else if (msel[5]) begin
            next_mode[msel[4:0]] = I_PWDATA[4:0];
         end
      end
      // a level may be stored before the pin is an output
      if (pw_wr && pin_ok(pw_pin) && !smooth_pin) begin
         next_static_lvl[5'(pw_pin - 5'h01)] = |I_PWDATA[PW_VAL_LSB +: 12]; // [R17]
      end
      if (abort_now) begin
         for (int s = 0; s < NUM_SLOTS; s++) begin
            if (slot_act[s] && pin_ok(slot_pin[s])) begin
               next_static_lvl[5'(slot_pin[s] - 5'h01)] = 1'b0; // [R15]
            end
         end
      end
   end

   // ======================================================================
   // slot pool: reuse the pin's own slot, else the lowest free one
   always_comb begin
      logic hit_found, free_found;
      logic [2:0] hit_idx, free_idx;
      hit_found = 1'b0;
      free_found = 1'b0;
      hit_idx = 3'h0;
      free_idx = 3'h0;
      next_slot_act = slot_act;
      next_slot_pin = slot_pin;
      slot_load = '0;
      slot_stop = '0;
      next_refused = refused;
      if (wr_en && I_PADDR == ADDR_STATUS && I_PWDATA[ST_REFUSED_BIT]) begin
         next_refused = 1'b0;
      end
      for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
         if (slot_act[s] && slot_pin[s] == cmd_cur.pin) begin
            hit_found = 1'b1;
            hit_idx = 3'(s);
         end
         if (!slot_act[s]) begin
            free_found = 1'b1;
            free_idx = 3'(s);
         end
      end
      if (abort_now || clear_all) begin
         next_slot_act = '0; // [R4] [R15]
         slot_stop = '1;
      end else if (go_cmd) begin
         if (!pin_ok(cmd_cur.pin)) begin
            next_refused = 1'b1; // [R7]
         end else if (cmd_cur.high == 12'h000 && cmd_cur.low == 17'h00000) begin
            if (hit_found) begin
               next_slot_act[hit_idx] = 1'b0; // [R5]
               slot_stop[hit_idx] = 1'b1;
            end
         end else if (hit_found) begin
            slot_load[hit_idx] = 1'b1; // [R19]
         end else if (free_found) begin
            slot_load[free_idx] = 1'b1;
            next_slot_act[free_idx] = 1'b1;
            next_slot_pin[free_idx] = cmd_cur.pin;
         end else begin
            next_refused = 1'b1; // [R1]
         end
      end
   end

   // ======================================================================
   // channels, one per slot
   generate
      for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_chan
         tpw_chan u_chan (
            .i_clk(I_CLK_SYS),
            .i_rst(I_SYS_RST),
            .i_tick(tick), // [R2]
            .i_load(slot_load[g]),
            .i_stop(slot_stop[g]),
            .i_cfg(load_cfg),
            .o_level(chan_lvl[g])
         );
      end
   endgenerate

   // ======================================================================
   // pin drivers; pins not set as outputs stay released
   always_comb begin
      logic lvl;
      logic [4:0] m;
      lvl = 1'b0;
      m = RST_MODE;
      for (int p = 0; p < NUM_PINS; p++) begin
         lvl = static_lvl[p];
         m = mode[p];
         for (int s = 0; s < NUM_SLOTS; s++) begin
            if (slot_act[s] && slot_pin[s] == 5'(p + 1)) begin
               lvl = chan_lvl[s];
            end
         end
         next_pin_out[p] = 1'b0;
         next_pin_oe_n[p] = 1'b1; // [R3]
         if (m == MODE_OUT_PP || m == MODE_PCT_PP || m == MODE_PM_PP) begin
            next_pin_out[p] = lvl; // [R17]
            next_pin_oe_n[p] = 1'b0;
         end else if (m == MODE_OUT_OD || m == MODE_PCT_OD || m == MODE_PM_OD) begin
            next_pin_oe_n[p] = lvl; // [R17] released for one, sinks for zero
         end
      end
   end

   // ======================================================================
   // register bank
   always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         cmd_pin <= 5'h00;
         cmd_high <= 12'h000;
         cmd_low <= 17'h00000;
         mode <= '{default: RST_MODE};
         static_lvl <= 20'h00000;
         slot_act <= '0;
         slot_pin <= '{default: 5'h00};
         refused <= 1'b0;
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         pin_out <= 20'h00000;
         pin_oe_n <= 20'hFFFFF;
      end else begin
         cmd_pin <= next_cmd_pin;
         cmd_high <= next_cmd_high;
         cmd_low <= next_cmd_low;
         mode <= next_mode;
         static_lvl <= next_static_lvl;
         slot_act <= next_slot_act;
         slot_pin <= next_slot_pin;
         refused <= next_refused;
         pready <= next_pready;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         pin_out <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
      end
   end

   assign O_PREADY = pready;
   assign O_PRDATA = prdata;
   assign O_PSLVERR = pslverr;
   assign O_PIN_LEVEL = pin_out;
   assign O_PIN_OE_N = pin_oe_n;

   // ======================================================================
   // checks
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_SYS_RST);

   tick_period_a: assert property (tick |-> $past(div_cnt) == 16'(P_TICK_CYCLES - 1)) // [R2]
      else $error("tick not one divider period apart");
   pool_full_a: assert property ( // [R1]
      (go_cmd && !abort_now && !clear_all && pin_ok(cmd_cur.pin) && &slot_act && !hit_found_w()
       && cmd_cur.high != 12'h000) |=> refused && $stable(slot_act))
      else $error("ninth channel was granted");
   clear_all_a: assert property ((clear_all && !abort_now) |=> slot_act == '0) // [R4]
      else $error("clear left a channel active");
   bad_pin_a: assert property ( // [R7]
      (go_cmd && !abort_now && !clear_all && cmd_cur.pin > 5'(NUM_PINS)) |=> refused)
      else $error("pin above range not refused");
   pct_sat_a: assert property ( // [R10]
      (go_cmd && cmd_cur.low == LOW_ARG_PCT && cmd_cur.high > PCT_FULL)
      |-> load_cfg.hi == PCT_FULL && load_cfg.lo == 12'h000)
      else $error("percentage not saturated");
   smooth_code_a: assert property ( // [R11] [R12]
      (go_cmd && cmd_cur.low == LOW_SMOOTH_PM) |-> load_cfg.kind == TPW_KIND_SMOOTH
      && load_cfg.win == WIN_PM)
      else $error("per-mille code not decoded");
   abort_low_a: assert property ( // [R15]
      ab_s2 |=> slot_act == '0 ##1 (pin_out & ~static_lvl) == 20'h00000)
      else $error("abort left pwm running");
   load_c: cover property (go_cmd && |slot_load);
   refuse_c: cover property (!refused ##1 refused);
   abort_c: cover property (ab_s2 && |slot_act);

   function automatic logic hit_found_w();
      hit_found_w = 1'b0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         if (slot_act[s] && slot_pin[s] == cmd_cur.pin) begin
            hit_found_w = 1'b1;
         end
      end
   endfunction
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the tick based pwm block
`timescale 1ns/100ps
`default_nettype none
module tb;
   import tpw_pkg::*;
   localparam int TK = 20;
   logic clk, rst, psel, pen, pwr, abt, perr, rdy, err;
   logic [7:0] pa;
   logic [31:0] pwd, rdata, prd;
   logic [19:0] lvl, oen;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int hc[20];
   int tg[20];
   tpw_top #(.P_TICK_CYCLES(TK)) tpw_top_i (.I_CLK_SYS(clk), .I_SYS_RST(rst),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
      .O_PREADY(rdy), .O_PRDATA(prd), .O_PSLVERR(err), .I_USER_ABORT(abt),
      .O_PIN_LEVEL(lvl), .O_PIN_OE_N(oen));
   // ====
   // clock, timeout and verdict
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // a hung handshake ends the run here
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   // ====
   // bus and compare tasks
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // request held until ready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      do @(posedge clk); while (rdy !== 1'h1);
      rdata = prd;
      perr = err;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic cmd(input logic [4:0] p, input logic [11:0] h, input logic [16:0] l);
      apb(1'h1, ADDR_CMD_PIN, {27'h0, p});
      apb(1'h1, ADDR_CMD_HIGH, {20'h0, h});
      apb(1'h1, ADDR_CMD_LOW, {15'h0, l});
      apb(1'h1, ADDR_CMD_CTRL, 32'h1);
   endtask
   task automatic stat(input logic [31:0] ex);
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk("status", ex, rdata);
   endtask
   // one sample per tick, so any phase gives exact counts
   task automatic meas(input int n);
      logic [19:0] pv;
      pv = lvl;
      hc = '{default: 0};
      tg = '{default: 0};
      repeat (n) begin
         repeat (TK) @(posedge clk);
         for (int p = 0; p < 20; p++) begin
            hc[p] += int'(lvl[p]);
            tg[p] += int'(lvl[p] != pv[p]);
         end
         pv = lvl;
      end
   endtask
   // ====
   // tests
   initial begin
      {rst, psel, pen, pwr, abt, pa, pwd} = {5'h10, 8'h0, 32'h0};
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      apb(1'h0, ADDR_MODE_BASE, 32'h0);
      chk("mode", 32'h0, rdata);
      chk("oe", 32'hFFFFF, {12'h0, oen});
      apb(1'h0, 8'hFC, 32'h0);
      chk("unmapped", 32'h1, {31'h0, perr});
      $display("test reset done");
      for (int p = 3; p <= 10; p++) apb(1'h1, 8'(ADDR_MODE_BASE + 4 * (p - 1)), 32'h8);
      apb(1'h1, 8'h54, {27'h0, MODE_PCT_PP});
      apb(1'h1, 8'h58, {27'h0, MODE_PM_PP});
      cmd(5'h03, 12'h002, 17'h00003);
      cmd(5'h04, 12'h01E, LOW_ARG_PCT);
      cmd(5'h05, 12'h096, LOW_ARG_PCT);
      apb(1'h1, ADDR_PIN_WRITE, 32'h0032_0006);
      apb(1'h1, ADDR_PIN_WRITE, 32'h01F4_0007);
      cmd(5'h08, 12'h032, LOW_SMOOTH_PCT);
      cmd(5'h09, 12'h1F4, LOW_SMOOTH_PM);
      cmd(5'h0A, CNT_MAX, 17'h00001);
      repeat (5 * TK) @(posedge clk);
      meas(100);
      chk("explicit", 32'd40, hc[2]);
      chk("percent", 32'd30, hc[3]);
      chk("saturate", 32'd100, hc[4]);
      chk("long high", 32'd100, hc[9]);
      for (int p = 5; p < 9; p++) begin
         chk("smooth", 32'd50, hc[p]);
         chk("toggle", 32'h1, {31'h0, tg[p] >= 98});
      end
      $display("test waveforms done");
      stat(32'hFF);
      cmd(5'h0B, 12'h00A, 17'h0000A);
      stat(32'h1FF);
      apb(1'h1, ADDR_STATUS, 32'h100);
      cmd(5'h0A, 12'h000, 17'h00000);
      stat(32'h7F);
      cmd(5'h0B, 12'h00A, 17'h0000A);
      stat(32'hFF);
      cmd(5'h15, 12'h00A, 17'h0000A);
      stat(32'h1FF);
      cmd(5'h00, 12'h000, 17'h00000);
      stat(32'h100);
      cmd(5'h03, 12'h00A, 17'h0000A);
      apb(1'h1, ADDR_CMD_CTRL, 32'h2);
      stat(32'h100);
      $display("test slots done");
      apb(1'h1, ADDR_MODE_LAST, {27'h0, MODE_OUT_OD});
      cmd(5'h14, 12'h064, LOW_ARG_PCT);
      cmd(5'h03, 12'h064, LOW_ARG_PCT);
      repeat (3 * TK) @(posedge clk);
      chk("led released", 32'h1, {31'h0, oen[19]});
      chk("pp high", 32'h1, {31'h0, lvl[2]});
      // stored levels of pwm pins must be dropped by the abort
      apb(1'h1, ADDR_PIN_WRITE, 32'h0001_0003);
      apb(1'h1, ADDR_PIN_WRITE, 32'h0001_0014);
      abt <= 1'h1;
      repeat (2 * TK) @(posedge clk);
      chk("abort lvl", 32'h0, {12'h0, lvl});
      chk("abort od", 32'h0, {31'h0, oen[19]});
      stat(32'h100);
      apb(1'h0, ADDR_LEVELS, 32'h0);
      chk("levels", 32'h0, rdata);
      abt <= 1'h0;
      $display("test abort done");
      final_report();
   end
endmodule
`default_nettype wire
